//--- rtl/hscc_map.vh
// Register map, field positions, reset values and timing counts of the
// high-speed clock control block. Included by hscc_top, the bench and hscc_chk.
`ifndef HSCC_MAP_VH
`define HSCC_MAP_VH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define HSCC_ADDR_W        4
`define HSCC_OFS_OSC_MODE  4'h0
`define HSCC_OFS_CLK_OP    4'h1
`define HSCC_OFS_STAB_STAT 4'h2
`define HSCC_OFS_STAB_SEL  4'h3
`define HSCC_OFS_SYS_CLK   4'h4
`define HSCC_OFS_PER_GATE  4'h5
`define HSCC_OFS_STOP_CMD  4'h6
// ----------------------------------------------------------------------
// Oscillator mode fields
// ----------------------------------------------------------------------
`define HSCC_OM_EXT_CLK    7
`define HSCC_OM_MAIN_PIN   6
`define HSCC_OM_SUB_PIN    4
`define HSCC_OM_GAIN       0
`define HSCC_OM_WMASK      8'hD7
// ----------------------------------------------------------------------
// Clock operation fields
// ----------------------------------------------------------------------
`define HSCC_CO_HS_STOP    7
`define HSCC_CO_IHS_STOP   0
// ----------------------------------------------------------------------
// System clock fields
// ----------------------------------------------------------------------
`define HSCC_SC_SUB_STAT   7
`define HSCC_SC_MAIN_STAT  5
`define HSCC_SC_MAIN_SEL   4
`define HSCC_SC_DIV_MSB    2
`define HSCC_SC_DIV_MAX    3'h5
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define HSCC_RST_OSC_MODE  8'h00
`define HSCC_RST_CLK_OP    8'hC0
`define HSCC_RST_STAB_SEL  8'h07
`define HSCC_RST_SYS_CLK   8'h00
`define HSCC_RST_PER_GATE  8'h00
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define HSCC_STAB_BASE     8
`endif

//--- rtl/hscc_sync2.v
// Two-flop synchroniser for one pin level.
// Assumes the input may change at any time relative to mclk_in.
`timescale 1ns/10ps
module hscc_sync2 (
  input  wire mclk_in,
  input  wire rst_n_in,
  input  wire d_in,
  output wire q_out
);
  reg meta_q;
  reg sync_q;
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end
  assign q_out = sync_q;
endmodule // hscc_sync2

//--- rtl/hscc_top.v
// High-speed clock control: oscillator mode, start/stop, stabilization
// count, clock select and divide, peripheral clock gates.
// Assumes a single-cycle register port and a resonator clock on a pin.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "hscc_map.vh"
module hscc_top #(
  parameter STAB_W = 19
) (
  input  wire                      mclk_in,
  input  wire                      rst_n_in,
  input  wire [`HSCC_ADDR_W-1:0]   addr_in,
  input  wire [7:0]                wdata_in,
  input  wire                      wr_in,
  input  wire                      rd_in,
  output reg  [7:0]                rdata_out,
  input  wire                      stop_exec_in,
  input  wire                      stop_release_in,
  input  wire                      sub_clk_sel_in,
  input  wire                      res_clk_in,
  output wire                      res_enable_out,
  output wire                      res_gain_hi_out,
  output wire                      ext_clk_enable_out,
  output wire                      port_mode_out,
  output wire                      ihs_osc_run_out,
  output wire                      hs_clk_sel_out,
  output wire [2:0]                div_sel_out,
  output wire                      clk_en_out,
  output wire                      stopped_out,
  output wire [7:0]                per_clk_en_out
);
  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg  [7:0]        osc_mode_q;
  reg               osc_mode_done_q;
  reg  [7:0]        clk_op_q;
  reg  [2:0]        stab_sel_q;
  reg               main_sel_q;
  reg  [2:0]        div_q;
  reg  [7:0]        per_gate_q;
  reg               stop_q;
  reg  [STAB_W-1:0] stab_cnt_q;
  reg  [4:0]        div_cnt_q;
  reg               res_d1_q;
  wire              res_sync;
  reg  [7:0]        clk_op_d;
  reg  [2:0]        stab_sel_d;
  reg               main_sel_d;
  reg  [2:0]        div_d;
  reg  [7:0]        per_gate_d;
  reg               stop_d;
  reg  [STAB_W-1:0] stab_cnt_d;
  reg  [4:0]        div_cnt_d;
  reg  [7:0]        rdata_d;

  // ----------------------------------------------------------------------
  // Reset values at register width
  // ----------------------------------------------------------------------
  localparam [7:0] RST_OSC_MODE = `HSCC_RST_OSC_MODE;
  localparam [7:0] RST_CLK_OP   = `HSCC_RST_CLK_OP;
  localparam [7:0] RST_STAB_SEL = `HSCC_RST_STAB_SEL;
  localparam [7:0] RST_SYS_CLK  = `HSCC_RST_SYS_CLK;
  localparam [7:0] RST_PER_GATE = `HSCC_RST_PER_GATE;
  localparam [7:0] OM_WMASK     = `HSCC_OM_WMASK;

  // ----------------------------------------------------------------------
  // Stop states
  // ----------------------------------------------------------------------
  localparam ST_RUN  = 1'b0;
  localparam ST_STOP = 1'b1;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function [STAB_W-1:0] stab_limit;
    input [2:0] sel;
    begin
      stab_limit = {{(STAB_W-1){1'b0}}, 1'b1} << (`HSCC_STAB_BASE + sel);
    end
  endfunction

  function [4:0] div_mask;
    input [2:0] sel;
    begin
      div_mask = (sel > `HSCC_SC_DIV_MAX) ? 5'h1F : ((5'h01 << sel) - 5'h01);
    end
  endfunction

  function reg_hit;
    input [`HSCC_ADDR_W-1:0] addr;
    input [`HSCC_ADDR_W-1:0] ofs;
    begin
      reg_hit = (addr == ofs);
    end
  endfunction

  function [7:0] sys_status;
    input       sub_on;
    input       main_on;
    input [2:0] div_code;
    begin
      sys_status = {sub_on, 1'b0, main_on & ~sub_on, main_on, 1'b0, div_code};
    end
  endfunction

  wire wr_osc  = wr_in && reg_hit(addr_in, `HSCC_OFS_OSC_MODE);
  wire wr_cop  = wr_in && reg_hit(addr_in, `HSCC_OFS_CLK_OP);
  wire wr_ssel = wr_in && reg_hit(addr_in, `HSCC_OFS_STAB_SEL);
  wire wr_sys  = wr_in && reg_hit(addr_in, `HSCC_OFS_SYS_CLK);
  wire wr_per  = wr_in && reg_hit(addr_in, `HSCC_OFS_PER_GATE);
  wire wr_stop = wr_in && reg_hit(addr_in, `HSCC_OFS_STOP_CMD);

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  wire ext_mode = osc_mode_q[`HSCC_OM_EXT_CLK] & osc_mode_q[`HSCC_OM_MAIN_PIN];
  wire res_mode = ~osc_mode_q[`HSCC_OM_EXT_CLK] & osc_mode_q[`HSCC_OM_MAIN_PIN];
  wire hs_run   = ~clk_op_q[`HSCC_CO_HS_STOP] & ~stop_q;

  assign port_mode_out      = ~osc_mode_q[`HSCC_OM_MAIN_PIN];
  assign res_enable_out     = res_mode & hs_run;
  assign res_gain_hi_out    = res_mode & osc_mode_q[`HSCC_OM_GAIN];
  assign ext_clk_enable_out = ext_mode & hs_run;
  assign ihs_osc_run_out    = ~clk_op_q[`HSCC_CO_IHS_STOP] & ~stop_q;
  assign hs_clk_sel_out     = main_sel_q;
  assign div_sel_out        = div_q;
  assign stopped_out        = stop_q;
  assign per_clk_en_out     = per_gate_q & {8{~stop_q}};
  assign clk_en_out         = ~stop_q && ((div_cnt_q & div_mask(div_q)) == 5'h00);

  // ----------------------------------------------------------------------
  // Oscillator mode, one write only
  // ----------------------------------------------------------------------
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_mode_q      <= RST_OSC_MODE;
      osc_mode_done_q <= 1'b0;
    end else if (wr_osc && !osc_mode_done_q) begin
      osc_mode_q      <= wdata_in & OM_WMASK;
      osc_mode_done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always @* begin
    clk_op_d   = clk_op_q;
    stab_sel_d = stab_sel_q;
    main_sel_d = main_sel_q;
    div_d      = div_q;
    per_gate_d = per_gate_q;
    if (wr_cop) begin
      clk_op_d = {wdata_in[7], 6'h00, wdata_in[0]};
    end
    if (wr_ssel) begin
      stab_sel_d = wdata_in[2:0];
    end
    if (wr_sys) begin
      main_sel_d = wdata_in[`HSCC_SC_MAIN_SEL];
      div_d      = wdata_in[`HSCC_SC_DIV_MSB:0];
    end
    if (wr_per) begin
      per_gate_d = wdata_in;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_op_q   <= RST_CLK_OP;
      stab_sel_q <= RST_STAB_SEL[2:0];
      main_sel_q <= RST_SYS_CLK[`HSCC_SC_MAIN_SEL];
      div_q      <= RST_SYS_CLK[`HSCC_SC_DIV_MSB:0];
      per_gate_q <= RST_PER_GATE;
    end else begin
      clk_op_q   <= clk_op_d;
      stab_sel_q <= stab_sel_d;
      main_sel_q <= main_sel_d;
      div_q      <= div_d;
      per_gate_q <= per_gate_d;
    end
  end

  // ----------------------------------------------------------------------
  // Stop mode
  // ----------------------------------------------------------------------
  always @* begin
    case (stop_q)
      ST_RUN: begin
        stop_d = (stop_exec_in | wr_stop) ? ST_STOP : ST_RUN;
      end
      ST_STOP: begin
        stop_d = (stop_release_in & ~stop_exec_in & ~wr_stop) ? ST_RUN : ST_STOP;
      end
      default: begin
        stop_d = ST_RUN;
      end
    endcase
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stop_q <= ST_RUN;
    end else begin
      stop_q <= stop_d;
    end
  end

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  always @* begin
    div_cnt_d = div_cnt_q + 5'h01;
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt_q <= 5'h00;
    end else begin
      div_cnt_q <= div_cnt_d;
    end
  end

  // ----------------------------------------------------------------------
  // Stabilization counter on synchronised resonator edges
  // ----------------------------------------------------------------------
  hscc_sync2 u_res_sync (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .d_in     (res_clk_in),
    .q_out    (res_sync)
  );

  always @* begin
    stab_cnt_d = stab_cnt_q;
    if (!res_enable_out) begin
      stab_cnt_d = {STAB_W{1'b0}};
    end else if (res_sync && !res_d1_q && !(&stab_cnt_q)) begin
      stab_cnt_d = stab_cnt_q + {{(STAB_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      res_d1_q   <= 1'b0;
      stab_cnt_q <= {STAB_W{1'b0}};
    end else begin
      res_d1_q   <= res_sync;
      stab_cnt_q <= stab_cnt_d;
    end
  end

  // Status bits, one per stabilization step reached
  reg [7:0] stab_stat;
  integer   i;
  always @* begin
    stab_stat = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      stab_stat[7-i] = (stab_cnt_q >= stab_limit(i[2:0])) | ext_mode;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always @* begin
    rdata_d = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `HSCC_OFS_OSC_MODE:  rdata_d = osc_mode_q;
        `HSCC_OFS_CLK_OP:    rdata_d = clk_op_q;
        `HSCC_OFS_STAB_STAT: rdata_d = stab_stat;
        `HSCC_OFS_STAB_SEL:  rdata_d = {5'h00, stab_sel_q};
        `HSCC_OFS_SYS_CLK:   rdata_d = sys_status(sub_clk_sel_in, main_sel_q, div_q);
        `HSCC_OFS_PER_GATE:  rdata_d = per_gate_q;
        default:             rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rdata_d;
    end
  end
endmodule // hscc_top

//--- test/high_speed_clock_control_tb.sv
// Bench of the high-speed clock control block with a resonator model.
// Assumes hscc_top, hscc_chk and hscc_res_model are compiled before it.
`timescale 1ns/10ps
`include "hscc_map.vh"
module high_speed_clock_control_tb;
  reg        mclk_in = 1'h0, rst_n_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0;
  reg        sub_clk_sel_in = 1'h0, stop_exec_in = 1'h0, stop_release_in = 1'h0;
  reg  [3:0] addr_in = 4'h0;
  reg  [7:0] wdata_in = 8'h00;
  wire [7:0] rdata_out, per_clk_en_out;
  wire [2:0] div_sel_out;
  wire       res_clk_in, res_enable_out, res_gain_hi_out, ext_clk_enable_out, port_mode_out;
  wire       ihs_osc_run_out, hs_clk_sel_out, clk_en_out, stopped_out;
  integer    error_cnt = 0, num_checks = 0, i, n;
  always #25 mclk_in = ~mclk_in;
  hscc_top #(.STAB_W(19)) dut_u (
    .mclk_in            (mclk_in),
    .rst_n_in           (rst_n_in),
    .addr_in            (addr_in),
    .wdata_in           (wdata_in),
    .wr_in              (wr_in),
    .rd_in              (rd_in),
    .rdata_out          (rdata_out),
    .stop_exec_in       (stop_exec_in),
    .stop_release_in    (stop_release_in),
    .sub_clk_sel_in     (sub_clk_sel_in),
    .res_clk_in         (res_clk_in),
    .res_enable_out     (res_enable_out),
    .res_gain_hi_out    (res_gain_hi_out),
    .ext_clk_enable_out (ext_clk_enable_out),
    .port_mode_out      (port_mode_out),
    .ihs_osc_run_out    (ihs_osc_run_out),
    .hs_clk_sel_out     (hs_clk_sel_out),
    .div_sel_out        (div_sel_out),
    .clk_en_out         (clk_en_out),
    .stopped_out        (stopped_out),
    .per_clk_en_out     (per_clk_en_out)
  );
  hscc_res_model res_u (.en_in(res_enable_out | ext_clk_enable_out), .clk_out(res_clk_in));
  task chk(input [7:0] got, input [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task bus(input w, input [3:0] a, input [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= w;
    rd_in <= !w;
    @(posedge mclk_in);
    wr_in <= 1'h0;
    rd_in <= 1'h0;
    #1;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    bus(1'h0, a, 8'h00);
    chk(rdata_out, e);
  endtask
  task pulse(input rel);
    @(posedge mclk_in);
    if (rel) stop_release_in <= 1'h1;
    else stop_exec_in <= 1'h1;
    @(posedge mclk_in);
    stop_release_in <= 1'h0;
    stop_exec_in <= 1'h0;
    #1;
  endtask
  task do_reset;
    rst_n_in <= 1'h0;
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'h1;
  endtask
  task s_reset;
    #1 chk({port_mode_out, ihs_osc_run_out, hs_clk_sel_out}, 8'h06);
    rd(`HSCC_OFS_CLK_OP, 8'hC0);
    rd(`HSCC_OFS_STAB_SEL, 8'h07);
    rd(4'hF, 8'h00);
    @(posedge mclk_in) sub_clk_sel_in <= 1'h1;
    rd(`HSCC_OFS_SYS_CLK, 8'h80);
    @(posedge mclk_in) sub_clk_sel_in <= 1'h0;
  endtask
  task s_reson;
    bus(1'h1, `HSCC_OFS_OSC_MODE, 8'h50);
    bus(1'h1, `HSCC_OFS_OSC_MODE, 8'h80);
    rd(`HSCC_OFS_OSC_MODE, 8'h50);
    chk({port_mode_out, res_gain_hi_out, res_enable_out}, 8'h00);
    bus(1'h1, `HSCC_OFS_CLK_OP, 8'h00);
    chk(res_enable_out, 1'h1);
    for (n = 0; n < 2000 && rdata_out[7] !== 1'h1; n = n + 1) bus(1'h0, `HSCC_OFS_STAB_STAT, 8'h00);
    if (n == 2000) begin
      error_cnt = error_cnt + 1;
      results;
    end
    chk({hs_clk_sel_out, ihs_osc_run_out}, 8'h01);
    for (i = 0; i < 6; i = i + 1) begin
      bus(1'h1, `HSCC_OFS_SYS_CLK, 8'h10 | i[7:0]);
      chk({hs_clk_sel_out, 4'h0, div_sel_out}, 8'h80 | i[7:0]);
      n = 0;
      repeat (64) @(posedge mclk_in) #1 n = n + clk_en_out;
      chk(n[7:0], 8'h40 >> i);
      rd(`HSCC_OFS_SYS_CLK, 8'h30 | i[7:0]);
    end
    bus(1'h1, `HSCC_OFS_PER_GATE, 8'hA5);
    rd(`HSCC_OFS_PER_GATE, 8'hA5);
    bus(1'h1, `HSCC_OFS_PER_GATE, 8'h00);
    bus(1'h1, `HSCC_OFS_SYS_CLK, 8'h00);
    bus(1'h1, `HSCC_OFS_STAB_SEL, 8'h07);
    bus(1'h1, `HSCC_OFS_CLK_OP, 8'h81);
    chk({res_enable_out, ihs_osc_run_out}, 8'h00);
    bus(1'h1, `HSCC_OFS_CLK_OP, 8'h00);
    chk({res_enable_out, ihs_osc_run_out}, 8'h03);
    bus(1'h1, `HSCC_OFS_PER_GATE, 8'h5A);
    pulse(1'h0);
    chk({stopped_out, res_enable_out, clk_en_out, 5'h00}, 8'h80);
    chk(per_clk_en_out, 8'h00);
    pulse(1'h1);
    chk(stopped_out, 1'h0);
  endtask
  task s_ext;
    do_reset;
    bus(1'h1, `HSCC_OFS_OSC_MODE, 8'hC0);
    chk(ext_clk_enable_out, 1'h0);
    bus(1'h1, `HSCC_OFS_CLK_OP, 8'h00);
    chk({ext_clk_enable_out, res_enable_out}, 8'h02);
    rd(`HSCC_OFS_STAB_STAT, 8'hFF);
    bus(1'h1, `HSCC_OFS_STOP_CMD, 8'h00);
    chk({stopped_out, ext_clk_enable_out}, 8'h02);
    pulse(1'h1);
    bus(1'h1, `HSCC_OFS_CLK_OP, 8'h80);
    chk(ext_clk_enable_out, 1'h0);
  endtask
  task s_gain;
    do_reset;
    #1 chk({port_mode_out, ihs_osc_run_out, hs_clk_sel_out}, 8'h06);
    bus(1'h1, `HSCC_OFS_OSC_MODE, 8'h41);
    chk({port_mode_out, res_gain_hi_out, res_enable_out}, 8'h02);
  endtask
  initial begin
    do_reset;
    s_reset;
    s_reson;
    s_ext;
    s_gain;
    results;
  end
endmodule // high_speed_clock_control_tb
bind hscc_top hscc_chk chk_u (
  .mclk_in            (mclk_in),
  .rst_n_in           (rst_n_in),
  .addr_in            (addr_in),
  .wdata_in           (wdata_in),
  .wr_in              (wr_in),
  .rd_in              (rd_in),
  .rdata_out          (rdata_out),
  .stop_exec_in       (stop_exec_in),
  .sub_clk_sel_in     (sub_clk_sel_in),
  .res_enable_out     (res_enable_out),
  .ext_clk_enable_out (ext_clk_enable_out),
  .port_mode_out      (port_mode_out),
  .ihs_osc_run_out    (ihs_osc_run_out),
  .hs_clk_sel_out     (hs_clk_sel_out),
  .div_sel_out        (div_sel_out),
  .clk_en_out         (clk_en_out),
  .stopped_out        (stopped_out),
  .per_clk_en_out     (per_clk_en_out)
);

//--- test/hscc_chk.sv
// Port assertions of the high-speed clock control block.
// Assumes a bind onto hscc_top; sees its ports only.
`timescale 1ns/10ps
`include "hscc_map.vh"
module hscc_chk (
  input wire                    mclk_in,
  input wire                    rst_n_in,
  input wire [`HSCC_ADDR_W-1:0] addr_in,
  input wire [7:0]              wdata_in,
  input wire                    wr_in,
  input wire                    rd_in,
  input wire [7:0]              rdata_out,
  input wire                    stop_exec_in,
  input wire                    sub_clk_sel_in,
  input wire                    res_enable_out,
  input wire                    ext_clk_enable_out,
  input wire                    port_mode_out,
  input wire                    ihs_osc_run_out,
  input wire                    hs_clk_sel_out,
  input wire [2:0]              div_sel_out,
  input wire                    clk_en_out,
  input wire                    stopped_out,
  input wire [7:0]              per_clk_en_out
);
  reg       om_done_q;
  reg [7:0] om_val_q;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // First oscillator mode write only
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      om_done_q <= 1'h0;
      om_val_q  <= `HSCC_RST_OSC_MODE;
    end else if (wr_in && addr_in == `HSCC_OFS_OSC_MODE && !om_done_q) begin
      om_done_q <= 1'h1;
      om_val_q  <= wdata_in & `HSCC_OM_WMASK;
    end
  end
  reset_state_a: assert property (
    $rose(rst_n_in) |-> port_mode_out && ihs_osc_run_out && !hs_clk_sel_out) else $error("bad reset state");
  pin_mode_a: assert property (
    res_enable_out || ext_clk_enable_out |-> !port_mode_out && !(res_enable_out && ext_clk_enable_out))
    else $error("pin mode conflict");
  osc_once_a: assert property (
    rd_in && addr_in == `HSCC_OFS_OSC_MODE |=> rdata_out == $past(om_val_q)) else $error("mode reg");
  stop_halt_a: assert property (
    stop_exec_in |=> stopped_out && !res_enable_out && !ext_clk_enable_out && per_clk_en_out == 8'h00)
    else $error("stop did not halt");
  hs_stop_a: assert property (
    wr_in && addr_in == `HSCC_OFS_CLK_OP && wdata_in[7] |=> !res_enable_out && !ext_clk_enable_out)
    else $error("hs stop ignored");
  ihs_ctl_a: assert property (
    wr_in && addr_in == `HSCC_OFS_CLK_OP && !stop_exec_in && !stopped_out
    |=> ihs_osc_run_out == !$past(wdata_in[0])) else $error("internal osc control");
  gate_wr_a: assert property (
    wr_in && addr_in == `HSCC_OFS_PER_GATE && !stop_exec_in && !stopped_out
    |=> per_clk_en_out == $past(wdata_in)) else $error("gate write");
  div_wr_a: assert property (
    wr_in && addr_in == `HSCC_OFS_SYS_CLK
    |=> div_sel_out == $past(wdata_in[2:0]) && hs_clk_sel_out == $past(wdata_in[4])) else $error("div");
  div_one_a: assert property (
    !stopped_out && div_sel_out == 3'h0 && $stable(div_sel_out) |-> clk_en_out) else $error("div one");
  status_rd_a: assert property (
    rd_in && addr_in == `HSCC_OFS_SYS_CLK |=> rdata_out[7] == $past(sub_clk_sel_in)
    && rdata_out[5] == ($past(hs_clk_sel_out) && !$past(sub_clk_sel_in)))
    else $error("clock status");
endmodule // hscc_chk

//--- test/hscc_res_model.sv
// Resonator or external clock source on the shared pins.
// Assumes en_in is high while the block runs or accepts the source.
`timescale 1ns/10ps
module hscc_res_model #(
  parameter HALF_NS = 65
) (
  input  wire en_in,
  output reg  clk_out
);
  initial clk_out = 1'h0;
  // About 7.7 MHz, low gain range, above 4 MHz
  always begin
    #HALF_NS;
    clk_out = en_in ? ~clk_out : 1'h0;
  end
endmodule // hscc_res_model
